// File: core/port_wake_pkg.sv
// Shared constants for the port, sleep, wake and reset control block.
package port_wake_pkg;
   // Reference clock.
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned CLK_PER_US      = CLK_HZ / 1_000_000;

   // Register byte offsets on the bus.
   localparam logic [7:0]  OFS_FIRST_DATA  = 8'h00;
   localparam logic [7:0]  OFS_SECOND_DATA = 8'h04;
   localparam logic [7:0]  OFS_THIRD_DATA  = 8'h08;
   localparam logic [7:0]  OFS_FOURTH_DATA = 8'h0C;
   localparam logic [7:0]  OFS_FOURTH_DIR  = 8'h10;
   localparam logic [7:0]  OFS_FOURTH_ATTR = 8'h14;
   localparam logic [7:0]  OFS_INT_SYS     = 8'h18;
   localparam logic [7:0]  OFS_HALT_CTRL   = 8'h1C;
   localparam logic [7:0]  OFS_STATUS      = 8'h20;
   localparam logic [7:0]  OFS_PIN_LEVEL   = 8'h24;

   // Field positions.
   localparam int unsigned HALT_GO_BIT     = 0;
   localparam int unsigned ST_LVD_BIT      = 0;
   localparam int unsigned ST_WDT_BIT      = 1;
   localparam int unsigned ST_LVR_BIT      = 2;
   localparam int unsigned ST_SLEEP_BIT    = 3;
   localparam int unsigned OPT_W           = 3;

   // Reset values of the fourth port (input with pull-up) and of the system register; watchdog clear code.
   localparam logic [3:0]  FOURTH_DATA_RST = 4'hF;
   localparam logic [3:0]  FOURTH_DIR_RST  = 4'h0;
   localparam logic [3:0]  FOURTH_ATTR_RST = 4'hF;
   localparam logic [3:0]  INT_SYS_RST     = 4'h0;
   localparam logic [3:0]  WDT_CLEAR_VAL   = 4'hE;

   // Build-time pin options of the first three ports.
   localparam logic [2:0]  OPT_OUT_HIGH    = 3'h0;
   localparam logic [2:0]  OPT_OUT_LOW     = 3'h1;
   localparam logic [2:0]  OPT_IO_PULL     = 3'h2;
   localparam logic [2:0]  OPT_IO_OPEN     = 3'h3;
   localparam logic [2:0]  OPT_IN_PULL     = 3'h4;
   localparam logic [2:0]  OPT_IN_FLOAT    = 3'h5;

   // Scan pulse rate selection.
   localparam logic [1:0]  SCAN_15_625HZ   = 2'h0;
   localparam logic [1:0]  SCAN_31_25HZ    = 2'h1;
   localparam logic [1:0]  SCAN_62_5HZ     = 2'h2;
   localparam logic [1:0]  SCAN_125HZ      = 2'h3;

   // Times in their own units and derived cycle counts.
   localparam int unsigned POR_MS          = 16;
   localparam int unsigned STAB_US         = 60;
   localparam int unsigned WDT_MS          = 450;
   localparam int unsigned SCAN_BASE_HZ    = 125;
   localparam int unsigned SCAN_PULSE_US   = 20;
   localparam int unsigned WAKE_BLANK_CYC  = 8;
   localparam int unsigned POR_CYC         = POR_MS * 1000 * CLK_PER_US;
   localparam int unsigned STAB_CYC        = STAB_US * CLK_PER_US;
   localparam int unsigned WDT_CYC         = WDT_MS * 1000 * CLK_PER_US;
   localparam int unsigned SCAN_BASE_CYC   = CLK_HZ / SCAN_BASE_HZ;
   localparam int unsigned SCAN_PULSE_CYC  = SCAN_PULSE_US * CLK_PER_US;

   typedef enum logic [1:0] {
      ST_POR   = 2'h0,
      ST_RUN   = 2'h1,
      ST_HALT  = 2'h3,
      ST_STAB  = 2'h2
   } sys_state_e;
endpackage : port_wake_pkg

// File: core/port_wake_reset_control.sv
// Pin ports, sleep with key wake-up, power-on, low-voltage and watchdog reset control.
`timescale 1ns/100ps
module port_wake_reset_control #(
   parameter logic [17:0] PAIR_OPTIONS     = 18'h12492,
   parameter logic [15:0] SCAN_KEY_MASK    = 16'h0000,
   parameter logic [1:0]  SCAN_RATE_SEL    = port_wake_pkg::SCAN_15_625HZ,
   parameter logic [31:0] POR_CYCLES       = 32'(port_wake_pkg::POR_CYC),
   parameter logic [31:0] WDT_CYCLES       = 32'(port_wake_pkg::WDT_CYC),
   parameter logic [31:0] SCAN_BASE_CYCLES = 32'(port_wake_pkg::SCAN_BASE_CYC)
) (
   // Clock and reset.
   input  wire logic        REF_CLK_I,
   input  wire logic        RST_B_I,
   // Wishbone slave.
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   // Supply detectors.
   input  wire logic        LOW_VOLTAGE_RESET_I,
   input  wire logic        LOW_VOLTAGE_DETECT_I,
   // First port pins.
   input  wire logic [3:0]  FIRST_PORT_PINS_I,
   output logic      [3:0]  FIRST_PORT_PINS_O,
   output logic      [3:0]  FIRST_PORT_PINS_OE_O,
   output logic      [3:0]  FIRST_PORT_PULL_O,
   // Second port pins.
   input  wire logic [3:0]  SECOND_PORT_PINS_I,
   output logic      [3:0]  SECOND_PORT_PINS_O,
   output logic      [3:0]  SECOND_PORT_PINS_OE_O,
   output logic      [3:0]  SECOND_PORT_PULL_O,
   // Third port pins.
   input  wire logic [3:0]  THIRD_PORT_PINS_I,
   output logic      [3:0]  THIRD_PORT_PINS_O,
   output logic      [3:0]  THIRD_PORT_PINS_OE_O,
   output logic      [3:0]  THIRD_PORT_PULL_O,
   // Fourth port pins.
   input  wire logic [3:0]  FOURTH_PORT_PINS_I,
   output logic      [3:0]  FOURTH_PORT_PINS_O,
   output logic      [3:0]  FOURTH_PORT_PINS_OE_O,
   output logic      [3:0]  FOURTH_PORT_PULL_O,
   // Core control.
   output logic             SYS_RST_B_O,
   output logic             CORE_CLK_EN_O
);

   localparam logic [31:0] STAB_CYCLES  = 32'(port_wake_pkg::STAB_CYC);
   localparam logic [31:0] PULSE_CYCLES = 32'(port_wake_pkg::SCAN_PULSE_CYC);
   localparam logic [3:0]  BLANK_CYCLES = 4'(port_wake_pkg::WAKE_BLANK_CYC);
   localparam logic [31:0] SCAN_PERIOD  = SCAN_BASE_CYCLES << (2'h3 - SCAN_RATE_SEL);

   // Drive decode for one pin of the first three ports: {oe, out, pull}.
   function automatic logic [2:0] opt_drive(input logic [2:0] opt, input logic d);
      logic [2:0] r;
      r = 3'h0;
      case (opt)
         port_wake_pkg::OPT_OUT_HIGH,
         port_wake_pkg::OPT_OUT_LOW:  r = {1'b1, d, 1'b0};
         port_wake_pkg::OPT_IO_PULL:  r = d ? 3'h1 : 3'h4;
         port_wake_pkg::OPT_IO_OPEN:  r = d ? 3'h0 : 3'h4;
         port_wake_pkg::OPT_IN_PULL,
         port_wake_pkg::OPT_IN_FLOAT: r = {2'h0, d};
         default:                     r = 3'h0;
      endcase
      return r;
   endfunction : opt_drive

   // Reset value of the data bits from the build options.
   function automatic logic [11:0] data_reset(input logic [17:0] opts);
      logic [11:0] v;
      logic [2:0]  o;
      v = 12'h000;
      for (int i = 0; i < 12; i++) begin
         o = opts[(i / 2) * 3 +: 3];
         v[i] = !(o == port_wake_pkg::OPT_OUT_LOW || o == port_wake_pkg::OPT_IN_FLOAT);
      end
      return v;
   endfunction : data_reset
   localparam logic [11:0] ABC_DATA_RST = data_reset(PAIR_OPTIONS);
   // Input synchronisers and filters.
   logic [17:0]             sync1_ff;
   logic [17:0]             sync2_ff;
   logic [17:0]             sync3_ff;
   logic [17:0]             filt_ff;
   logic [17:0]             raw_in;
   logic [15:0]             pin_lvl;
   logic                    lvr_act;
   logic                    lvd_low;
   // Register file.
   logic [11:0]             abc_data_ff;
   logic [3:0]              d_data_ff;
   logic [3:0]              d_dir_ff;
   logic [3:0]              d_attr_ff;
   logic [3:0]              int_sys_ff;
   logic                    wdt_cause_ff;
   logic                    lvr_cause_ff;
   logic                    ack_ff;
   logic [31:0]             rdata_ff;
   // Sequencer.
   port_wake_pkg::sys_state_e state_ff;
   port_wake_pkg::sys_state_e nxt_state;
   logic [31:0]             cnt_ff;
   logic [31:0]             nxt_cnt;
   logic [31:0]             wdt_ff;
   logic [31:0]             scan_ff;
   logic [3:0]              blank_ff;
   // Pin drive registers.
   logic [15:0]             oe_ff;
   logic [15:0]             out_ff;
   logic [15:0]             pull_ff;
   logic [15:0]             nxt_oe;
   logic [15:0]             nxt_out;
   logic [15:0]             nxt_pull;
   assign raw_in = {LOW_VOLTAGE_DETECT_I, LOW_VOLTAGE_RESET_I, FOURTH_PORT_PINS_I,
                    THIRD_PORT_PINS_I, SECOND_PORT_PINS_I, FIRST_PORT_PINS_I};
   assign pin_lvl = filt_ff[15:0];
   assign lvr_act = filt_ff[16];
   assign lvd_low = filt_ff[17];

   // A level counts once the second and third stages agree.
   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         sync1_ff <= 18'h0FFFF;
         sync2_ff <= 18'h0FFFF;
         sync3_ff <= 18'h0FFFF;
         filt_ff  <= 18'h0FFFF;
      end else begin
         sync1_ff <= raw_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         filt_ff  <= (sync2_ff & ~(sync2_ff ^ sync3_ff)) | (filt_ff & (sync2_ff ^ sync3_ff));
      end
   end

   // Bus decode.
   logic                    req;
   logic                    wr;
   logic                    wr_lo;
   logic                    running;
   logic                    sel_a;
   logic                    sel_b;
   logic                    sel_c;
   logic                    sel_dd;
   logic                    sel_ddir;
   logic                    sel_dattr;
   logic                    sel_int;
   logic                    sel_halt;
   logic                    sel_st;
   logic                    sel_lvl;
   logic                    wdt_clear;
   logic                    halt_go;
   logic [31:0]             rmux;
   logic [3:0]              status;

   assign req       = WB_CYC_I & WB_STB_I & ~ack_ff;
   assign wr        = req & WB_WE_I;
   assign wr_lo     = wr & WB_SEL_I[0];
   assign running   = (state_ff == port_wake_pkg::ST_RUN);
   assign sel_a     = (WB_ADR_I == port_wake_pkg::OFS_FIRST_DATA);
   assign sel_b     = (WB_ADR_I == port_wake_pkg::OFS_SECOND_DATA);
   assign sel_c     = (WB_ADR_I == port_wake_pkg::OFS_THIRD_DATA);
   assign sel_dd    = (WB_ADR_I == port_wake_pkg::OFS_FOURTH_DATA);
   assign sel_ddir  = (WB_ADR_I == port_wake_pkg::OFS_FOURTH_DIR);
   assign sel_dattr = (WB_ADR_I == port_wake_pkg::OFS_FOURTH_ATTR);
   assign sel_int   = (WB_ADR_I == port_wake_pkg::OFS_INT_SYS);
   assign sel_halt  = (WB_ADR_I == port_wake_pkg::OFS_HALT_CTRL);
   assign sel_st    = (WB_ADR_I == port_wake_pkg::OFS_STATUS);
   assign sel_lvl   = (WB_ADR_I == port_wake_pkg::OFS_PIN_LEVEL);
   assign wdt_clear = wr_lo & sel_int & (WB_DAT_I[3:0] == port_wake_pkg::WDT_CLEAR_VAL);
   assign halt_go   = wr_lo & sel_halt & WB_DAT_I[port_wake_pkg::HALT_GO_BIT] & running;
   always_comb begin
      status = 4'h0;
      status[port_wake_pkg::ST_LVD_BIT]   = ~lvd_low;
      status[port_wake_pkg::ST_WDT_BIT]   = wdt_cause_ff;
      status[port_wake_pkg::ST_LVR_BIT]   = lvr_cause_ff;
      status[port_wake_pkg::ST_SLEEP_BIT] = (state_ff == port_wake_pkg::ST_HALT);
   end
   assign rmux = sel_a     ? {28'h0, abc_data_ff[3:0]}  :
                 sel_b     ? {28'h0, abc_data_ff[7:4]}  :
                 sel_c     ? {28'h0, abc_data_ff[11:8]} :
                 sel_dd    ? {28'h0, d_data_ff}         :
                 sel_ddir  ? {28'h0, d_dir_ff}          :
                 sel_dattr ? {28'h0, d_attr_ff}         :
                 sel_int   ? {28'h0, int_sys_ff}        :
                 sel_st    ? {28'h0, status}            :
                 sel_lvl   ? {16'h0, pin_lvl}           : 32'h0;

   // Every access, mapped or not, is answered one cycle after it is seen.
   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h0;
      end else begin
         ack_ff   <= req;
         rdata_ff <= (req & ~WB_WE_I) ? rmux : 32'h0;
      end
   end

   // Port registers; a system reset returns them to their build-time values.
   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         abc_data_ff <= ABC_DATA_RST;
         d_data_ff   <= port_wake_pkg::FOURTH_DATA_RST;
         d_dir_ff    <= port_wake_pkg::FOURTH_DIR_RST;
         d_attr_ff   <= port_wake_pkg::FOURTH_ATTR_RST;
         int_sys_ff  <= port_wake_pkg::INT_SYS_RST;
      end else if (state_ff == port_wake_pkg::ST_POR) begin
         abc_data_ff <= ABC_DATA_RST;
         d_data_ff   <= port_wake_pkg::FOURTH_DATA_RST;
         d_dir_ff    <= port_wake_pkg::FOURTH_DIR_RST;
         d_attr_ff   <= port_wake_pkg::FOURTH_ATTR_RST;
         int_sys_ff  <= port_wake_pkg::INT_SYS_RST;
      end else if (wr_lo) begin
         if (sel_a)     abc_data_ff[3:0]  <= WB_DAT_I[3:0];
         if (sel_b)     abc_data_ff[7:4]  <= WB_DAT_I[3:0];
         if (sel_c)     abc_data_ff[11:8] <= WB_DAT_I[3:0];
         if (sel_dd)    d_data_ff         <= WB_DAT_I[3:0];
         if (sel_ddir)  d_dir_ff          <= WB_DAT_I[3:0];
         if (sel_dattr) d_attr_ff         <= WB_DAT_I[3:0];
         if (sel_int)   int_sys_ff        <= WB_DAT_I[3:0];
      end
   end

   // Scan pulse timing and wake detection; this logic stays on while the core clock is off.
   logic                    asleep;
   logic                    pulse;
   logic                    wake;
   logic                    wdt_expire;
   assign asleep     = (state_ff == port_wake_pkg::ST_HALT);
   assign pulse      = asleep & (scan_ff < PULSE_CYCLES);
   assign wake       = asleep & ~pulse & (blank_ff == 4'h0) & |(~oe_ff & ~pin_lvl);
   assign wdt_expire = running & (wdt_ff >= WDT_CYCLES - 32'h1);

   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         scan_ff  <= 32'h0;
         blank_ff <= 4'h0;
      end else begin
         scan_ff  <= (!asleep || scan_ff >= SCAN_PERIOD - 32'h1) ? 32'h0 : scan_ff + 32'h1;
         blank_ff <= (pulse || !asleep) ? BLANK_CYCLES :
                     (blank_ff != 4'h0) ? blank_ff - 4'h1 : 4'h0;
      end
   end

   // Sequencer: power-on hold, run, sleep and stabilisation.
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff + 32'h1;
      case (state_ff)
         port_wake_pkg::ST_POR: begin
            if (cnt_ff >= POR_CYCLES - 32'h1) begin
               nxt_state = port_wake_pkg::ST_RUN;
               nxt_cnt   = 32'h0;
            end
         end
         port_wake_pkg::ST_RUN: begin
            nxt_cnt = 32'h0;
            if (wdt_expire) begin
               nxt_state = port_wake_pkg::ST_POR;
            end else if (halt_go) begin
               nxt_state = port_wake_pkg::ST_HALT;
            end
         end
         port_wake_pkg::ST_HALT: begin
            nxt_cnt = 32'h0;
            if (wake) begin
               nxt_state = port_wake_pkg::ST_STAB;
            end
         end
         port_wake_pkg::ST_STAB: begin
            if (cnt_ff >= STAB_CYCLES - 32'h1) begin
               nxt_state = port_wake_pkg::ST_RUN;
               nxt_cnt   = 32'h0;
            end
         end
         default: begin
            nxt_state = port_wake_pkg::ST_POR;
            nxt_cnt   = 32'h0;
         end
      endcase
      if (lvr_act) begin
         nxt_state = port_wake_pkg::ST_POR;
         nxt_cnt   = 32'h0;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         state_ff      <= port_wake_pkg::ST_POR;
         cnt_ff        <= 32'h0;
         SYS_RST_B_O   <= 1'b0;
         CORE_CLK_EN_O <= 1'b0;
      end else begin
         state_ff      <= nxt_state;
         cnt_ff        <= nxt_cnt;
         SYS_RST_B_O   <= (nxt_state != port_wake_pkg::ST_POR);
         CORE_CLK_EN_O <= (nxt_state == port_wake_pkg::ST_RUN);
      end
   end

   // Watchdog counts only while the core runs and restarts after any sleep or reset.
   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         wdt_ff <= 32'h0;
      end else if (!running || wdt_clear || wdt_expire) begin
         wdt_ff <= 32'h0;
      end else begin
         wdt_ff <= wdt_ff + 32'h1;
      end
   end

   // Reset cause flags hold until the next reset of the other kind.
   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         wdt_cause_ff <= 1'b0;
         lvr_cause_ff <= 1'b0;
      end else if (lvr_act) begin
         wdt_cause_ff <= 1'b0;
         lvr_cause_ff <= 1'b1;
      end else if (wdt_expire) begin
         wdt_cause_ff <= 1'b1;
         lvr_cause_ff <= 1'b0;
      end
   end
   // Pin drive decode, one generate branch per pin.
   for (genvar i = 0; i < 16; i++) begin : g_pin
      logic [2:0] drv;
      logic [2:0] fin;
      if (i < 12) begin : g_opt
         // Pins 0/1 and 2/3 of a port share one option word.
         assign drv = opt_drive(PAIR_OPTIONS[(i / 2) * 3 +: 3], abc_data_ff[i]);
      end else begin : g_reg
         assign drv = d_dir_ff[i - 12] ? {1'b1, d_data_ff[i - 12], 1'b0} :
                                         {2'h0, d_attr_ff[i - 12]};
      end
      if (SCAN_KEY_MASK[i]) begin : g_scan
         assign fin = !asleep ? drv : (pulse ? 3'h4 : 3'h1);
      end else begin : g_plain
         assign fin = drv;
      end
      assign nxt_oe[i]   = fin[2];
      assign nxt_out[i]  = fin[1];
      assign nxt_pull[i] = fin[0];
   end

   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         oe_ff   <= 16'h0000;
         out_ff  <= 16'h0000;
         pull_ff <= 16'h0000;
      end else begin
         oe_ff   <= nxt_oe;
         out_ff  <= nxt_out;
         pull_ff <= nxt_pull;
      end
   end
   assign WB_ACK_O              = ack_ff;
   assign WB_DAT_O              = rdata_ff;
   assign FIRST_PORT_PINS_O     = out_ff[3:0];
   assign FIRST_PORT_PINS_OE_O  = oe_ff[3:0];
   assign FIRST_PORT_PULL_O     = pull_ff[3:0];
   assign SECOND_PORT_PINS_O    = out_ff[7:4];
   assign SECOND_PORT_PINS_OE_O = oe_ff[7:4];
   assign SECOND_PORT_PULL_O    = pull_ff[7:4];
   assign THIRD_PORT_PINS_O     = out_ff[11:8];
   assign THIRD_PORT_PINS_OE_O  = oe_ff[11:8];
   assign THIRD_PORT_PULL_O     = pull_ff[11:8];
   assign FOURTH_PORT_PINS_O    = out_ff[15:12];
   assign FOURTH_PORT_PINS_OE_O = oe_ff[15:12];
   assign FOURTH_PORT_PULL_O    = pull_ff[15:12];

endmodule : port_wake_reset_control

// File: sim/key_pad_model.sv
// Pads with key switches to ground, pull-ups and floating inputs.
`timescale 1ns/100ps
module key_pad_model (
   input  wire logic        clk_i,
   input  wire logic [15:0] oe_i,
   input  wire logic [15:0] out_i,
   input  wire logic [15:0] pull_i,
   input  wire logic [15:0] press_i,
   output logic      [15:0] pad_o
);
   logic flip_ff = 1'b0;
   // An undriven pad without pull-up wanders, so a floating input never reads stable.
   always @(posedge clk_i) flip_ff <= ~flip_ff;
   assign pad_o = (oe_i & out_i) | (~oe_i & ~press_i & (pull_i | {16{flip_ff}}));
endmodule : key_pad_model

// File: sim/port_wake_reset_control_test.sv
// Self-checking bench for the port, sleep and reset control block.
`timescale 1ns/100ps
module port_wake_reset_control_test;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic        low_voltage_reset = 1'b0;
   logic        low_voltage_detect_flag = 1'b0;
   logic [15:0] press = 16'h0000;
   logic [31:0] r;
   wire  logic [31:0] rdat;
   wire  logic        ack;
   wire  logic        sys_rst_b;
   wire  logic        clk_en;
   wire  logic [15:0] oe;
   wire  logic [15:0] po;
   wire  logic [15:0] pu;
   wire  logic [15:0] pad;
   int          failures = 0;
   int          compares = 0;
   int          cycles = 0;
   int          n;
   logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h30};
   logic [3:0]  re [8] = '{4'h3, 4'hF, 4'h3, 4'hF, 4'h0, 4'hF, 4'h0, 4'h0};
   port_wake_reset_control #(.PAIR_OPTIONS(18'h2C688), .SCAN_KEY_MASK(16'h1000),
      .SCAN_RATE_SEL(port_wake_pkg::SCAN_125HZ), .POR_CYCLES(32'h32), .WDT_CYCLES(32'h190),
      .SCAN_BASE_CYCLES(32'h7D0)) port_wake_reset_control_i (
      .REF_CLK_I(clk), .RST_B_I(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .LOW_VOLTAGE_RESET_I(low_voltage_reset), .LOW_VOLTAGE_DETECT_I(low_voltage_detect_flag),
      .FIRST_PORT_PINS_I(pad[3:0]), .FIRST_PORT_PINS_O(po[3:0]),
      .FIRST_PORT_PINS_OE_O(oe[3:0]), .FIRST_PORT_PULL_O(pu[3:0]),
      .SECOND_PORT_PINS_I(pad[7:4]), .SECOND_PORT_PINS_O(po[7:4]),
      .SECOND_PORT_PINS_OE_O(oe[7:4]), .SECOND_PORT_PULL_O(pu[7:4]),
      .THIRD_PORT_PINS_I(pad[11:8]), .THIRD_PORT_PINS_O(po[11:8]),
      .THIRD_PORT_PINS_OE_O(oe[11:8]), .THIRD_PORT_PULL_O(pu[11:8]),
      .FOURTH_PORT_PINS_I(pad[15:12]), .FOURTH_PORT_PINS_O(po[15:12]),
      .FOURTH_PORT_PINS_OE_O(oe[15:12]), .FOURTH_PORT_PULL_O(pu[15:12]),
      .SYS_RST_B_O(sys_rst_b), .CORE_CLK_EN_O(clk_en));
   key_pad_model key_pad_model_i (.clk_i(clk), .oe_i(oe), .out_i(po), .pull_i(pu),
      .press_i(press), .pad_o(pad));
   initial forever #10 clk = ~clk;
   task automatic give_verdict();
      if (failures == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         $display("[ERR] %0t run timed out", $time);
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 20) chk(32'h0, 32'h1, "no ack");
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [3:0] d);
      bus(1'b1, a, 4'hF, {28'h0, d});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 4'hF, 32'h0);
      chk(r & m, e, "read");
   endtask : rd
   // Driver, output value where driven, and pull-up of one port.
   task automatic pchk(input int p, input logic [11:0] e);
      repeat (2) @(posedge clk);
      #1;
      chk({20'h0, oe[4*p+:4], po[4*p+:4] & oe[4*p+:4], pu[4*p+:4]}, {20'h0, e}, "pins");
   endtask : pchk
   task automatic span(input logic v);
      n = 0;
      while (oe[12] === v && n < 2100) begin
         @(posedge clk);
         n++;
      end
   endtask : span
   task automatic hold(input logic v, input int lim);
      n = 0;
      while (sys_rst_b !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask : hold
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      hold(1'b1, 100);
      chk(32'(n >= 50 && n <= 53), 32'h1, "power-on hold");
      pchk(0, 12'hF30);
      pchk(1, 12'h003);
      pchk(2, 12'h003);
      pchk(3, 12'h00F);
      for (int i = 0; i < 8; i++) rd(ra[i], 32'hF, {28'h0, re[i]});
      wr(8'h18, 4'hE);
      wr(8'h00, 4'hA);
      pchk(0, 12'hFA0);
      bus(1'b1, 8'h00, 4'hE, 32'h5);
      rd(8'h00, 32'hF, 32'hA);
      rd(8'h24, 32'hF, 32'hA);
      wr(8'h04, 4'h5);
      pchk(1, 12'hA01);
      wr(8'h08, 4'h5);
      pchk(2, 12'h005);
      wr(8'h10, 4'h3);
      wr(8'h0C, 4'h2);
      pchk(3, 12'h32C);
      wr(8'h10, 4'h0);
      low_voltage_detect_flag <= 1'b1;
      repeat (6) @(posedge clk);
      rd(8'h20, 32'h1, 32'h0);
      low_voltage_detect_flag <= 1'b0;
      repeat (6) @(posedge clk);
      rd(8'h20, 32'h1, 32'h1);
      wr(8'h04, 4'h1);
      wr(8'h08, 4'hF);
      wr(8'h18, 4'hE);
      wr(8'h1C, 4'h1);
      repeat (2) @(posedge clk);
      chk(32'(clk_en), 32'h0, "sleep");
      span(1'b1);
      span(1'b0);
      span(1'b1);
      chk(n, 32'd1000, "scan pulse");
      span(1'b0);
      chk(n, 32'd1000, "scan gap");
      span(1'b1);
      repeat (20) @(posedge clk);
      press[14] <= 1'b1;
      n = 0;
      while (clk_en !== 1'b1 && n < 3100) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n >= 3000 && n <= 3012), 32'h1, "wake time");
      press[14] <= 1'b0;
      rd(8'h00, 32'hF, 32'hA);
      wr(8'h18, 4'hE);
      wr(8'h1C, 4'h1);
      repeat (20) @(posedge clk);
      low_voltage_reset <= 1'b1;
      repeat (10) @(posedge clk);
      chk(32'(sys_rst_b), 32'h0, "supply reset");
      low_voltage_reset <= 1'b0;
      hold(1'b1, 100);
      rd(8'h20, 32'h4, 32'h4);
      rd(8'h00, 32'hF, 32'h3);
      repeat (4) begin
         wr(8'h18, 4'hE);
         repeat (150) @(posedge clk);
      end
      chk(32'(sys_rst_b), 32'h1, "watchdog kept off");
      wr(8'h18, 4'hE);
      hold(1'b0, 500);
      chk(32'(n >= 395 && n <= 405), 32'h1, "watchdog expiry");
      hold(1'b1, 100);
      rd(8'h20, 32'h2, 32'h2);
      give_verdict();
   end
endmodule : port_wake_reset_control_test

// File: sim/port_wake_sva.sv
// Bus, reset and sleep timing checker bound to the control block.
`timescale 1ns/100ps
module port_wake_sva #(
   parameter logic [31:0] POR_CYCLES = 32'h32
) (
   input wire logic        REF_CLK_I,
   input wire logic        RST_B_I,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_ACK_O,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        LOW_VOLTAGE_RESET_I,
   input wire logic        SYS_RST_B_O,
   input wire logic        CORE_CLK_EN_O,
   input wire logic [3:0]  SECOND_PORT_PINS_OE_O,
   input wire logic [3:0]  SECOND_PORT_PULL_O,
   input wire logic [3:0]  FOURTH_PORT_PINS_OE_O,
   input wire logic [3:0]  FOURTH_PORT_PULL_O
);
   logic [15:0] off_cnt_ff;
   logic [31:0] rst_cnt_ff;
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_B_I);
   // Lengths of the current stopped-clock and core-reset stretches.
   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         off_cnt_ff <= 16'h0000;
         rst_cnt_ff <= 32'h0;
      end else begin
         off_cnt_ff <= CORE_CLK_EN_O ? 16'h0000 : off_cnt_ff + 16'h0001;
         rst_cnt_ff <= SYS_RST_B_O ? 32'h0 : rst_cnt_ff + 32'h1;
      end
   end
   a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held longer than one cycle");
   a_ack_next_cycle: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("request not answered in the next cycle");
   a_dat_idle_zero: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
      else $error("read data not zero outside ack");
   a_lvr_forces_reset: assert property (LOW_VOLTAGE_RESET_I [*8] |-> !SYS_RST_B_O)
      else $error("low supply did not reset the core");
   a_por_hold_time: assert property ($rose(SYS_RST_B_O) |-> rst_cnt_ff >= POR_CYCLES - 32'h1)
      else $error("core reset released too early");
   a_clk_off_reset: assert property (!SYS_RST_B_O |-> !CORE_CLK_EN_O)
      else $error("core clock runs in reset");
   a_wake_stab_time: assert property ($rose(CORE_CLK_EN_O) && $past(SYS_RST_B_O) |->
      off_cnt_ff >= 16'(port_wake_pkg::STAB_CYC))
      else $error("wake without full settling time");
   a_pull_not_driven: assert property (
      (SECOND_PORT_PULL_O & SECOND_PORT_PINS_OE_O) == 4'h0
      && (FOURTH_PORT_PULL_O & FOURTH_PORT_PINS_OE_O) == 4'h0)
      else $error("pull-up on a driven pin");
endmodule : port_wake_sva
bind port_wake_reset_control port_wake_sva #(.POR_CYCLES(POR_CYCLES)) port_wake_sva_i (
   .REF_CLK_I, .RST_B_I, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .WB_DAT_O, .LOW_VOLTAGE_RESET_I,
   .SYS_RST_B_O, .CORE_CLK_EN_O, .SECOND_PORT_PINS_OE_O, .SECOND_PORT_PULL_O,
   .FOURTH_PORT_PINS_OE_O, .FOURTH_PORT_PULL_O);
